// ---- design/ppm_pkg.sv ----
package ppm_pkg;
    // Clock rate and hold timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned HOLD_MS = 1000;
    localparam int unsigned HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_MS;
    localparam int unsigned REPEAT_MS = 100;
    localparam int unsigned REPEAT_CYCLES = (CLK_HZ / 1000) * REPEAT_MS;
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;
    localparam int unsigned MAX_DIGITS = 16;
    localparam int unsigned SHORT_DIGITS = 8;
    localparam logic [3:0] DIGIT_MIN = 4'h0;
    localparam logic [3:0] DIGIT_MAX = 4'hF;
    localparam logic [3:0] LAST_POS = 4'hF;

    // Menu items
    typedef enum logic [1:0] {
        PPM_ITEM_NONE,
        PPM_ITEM_PASSCODE,
        PPM_ITEM_CLEAR
    } ppm_item_t;

    // Screens shown by the display
    typedef enum logic [3:0] {
        PPM_SCR_IO_STATUS,
        PPM_SCR_MENU,
        PPM_SCR_NOT_SET,
        PPM_SCR_ENTRY_16,
        PPM_SCR_ENTRY_8,
        PPM_SCR_REENABLE,
        PPM_SCR_ALL_OK,
        PPM_SCR_BAD_CODE,
        PPM_SCR_CLEAR_ASK,
        PPM_SCR_RUNNING
    } ppm_screen_t;

    // Debounced button levels
    typedef struct packed {
        logic esc;
        logic minus;
        logic plus;
        logic ok;
    } ppm_buttons_t;

    // Passcode status from the main unit
    typedef struct packed {
        logic registered;
        logic long_code;
        logic cancelled;
    } ppm_code_state_t;

    // Display view
    typedef struct packed {
        ppm_screen_t screen;
        logic [63:0] digits;
        logic [3:0] cursor;
        logic blink_on;
    } ppm_view_t;
endpackage : ppm_pkg

// ---- design/ppm_menu.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - No path ever reveals or recovers the stored passcode.
// - OK on passcode item shows one of four screens per code state.
// - ESC from menu returns to main I/O status display.
// - Sixteen-digit code shows two lines, eight-digit code one line.
// - Entry starts at highest digit; active digit blinks.
// - Minus decrements digit; one-second hold repeats fast.
// - Plus increments digit; one-second hold repeats fast.
// - OK on non-final digit latches it and moves one lower.
// - OK on final digit compares; match cancels protection, shows success.
// - Mismatch shows incorrect message, protection stays.
// - ESC at highest digit abandons entry to menu.
// - ESC at lower digit discards it and moves one higher.
// - Re-enable screen: OK restores protection, returns; plus/minus ignored.
// - Re-enable screen: ESC keeps cancelled state, returns to menu.
// - All-clear only when stopped; relays off, data zeroed.
// - Clear hits outputs, relays, states, timers, counters, registers; not inputs, files.
// - Clear screen: OK clears and returns; ESC cancels; plus/minus ignored.
// - Running on OK shows running message; OK or ESC returns.
module ppm_menu #(
    parameter int unsigned HOLD_COUNT = ppm_pkg::HOLD_CYCLES,
    parameter int unsigned REPEAT_COUNT = ppm_pkg::REPEAT_CYCLES,
    parameter int unsigned BLINK_COUNT = ppm_pkg::BLINK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire ppm_pkg::ppm_buttons_t buttons,
    input wire ppm_pkg::ppm_item_t menu_item,
    input wire logic menu_select,
    input wire ppm_pkg::ppm_code_state_t code_state,
    input wire logic ctrl_stopped,
    input wire logic compare_done,
    input wire logic compare_match,
    output ppm_pkg::ppm_view_t view,
    output logic compare_req,
    output logic [63:0] compare_code,
    output logic protect_cancel,
    output logic protect_restore,
    output logic clear_req
);
    import ppm_pkg::*;

    // Entry start positions per code length
    localparam logic [3:0] SHORT_FIRST = 4'(MAX_DIGITS - SHORT_DIGITS);
    localparam logic [3:0] LONG_FIRST = 4'h0;

    typedef enum {
        ST_IO,
        ST_MENU,
        ST_NOT_SET,
        ST_ENTRY,
        ST_WAIT_CMP,
        ST_ALL_OK,
        ST_BAD,
        ST_REENABLE,
        ST_CLEAR_ASK,
        ST_RUNNING
    } ppm_state_t;

    ppm_state_t state_reg;
    ppm_buttons_t sync1_reg;
    ppm_buttons_t sync2_reg;
    ppm_buttons_t prev_reg;
    logic [3:0] pos_reg;
    logic [63:0] code_reg;
    logic [31:0] hold_reg;
    logic [31:0] rep_reg;
    logic [31:0] blink_cnt_reg;
    logic blink_reg;
    logic sel_sync1_reg;
    logic sel_sync2_reg;
    logic sel_prev_reg;
    logic stop_sync1_reg;
    logic stop_sync2_reg;
    logic long_reg;
    ppm_buttons_t press;
    logic sel_press;
    logic step_up;
    logic step_dn;
    logic repeat_tick;
    logic [3:0] first_pos;
    logic [3:0] cur_digit;

    // Pins from the panel are asynchronous
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
            sel_sync1_reg <= 1'b0;
            sel_sync2_reg <= 1'b0;
            sel_prev_reg <= 1'b0;
            stop_sync1_reg <= 1'b0;
            stop_sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= buttons;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            sel_sync1_reg <= menu_select;
            sel_sync2_reg <= sel_sync1_reg;
            sel_prev_reg <= sel_sync2_reg;
            stop_sync1_reg <= ctrl_stopped;
            stop_sync2_reg <= stop_sync1_reg;
        end
    end

    assign press = sync2_reg & ~prev_reg;
    assign sel_press = sel_sync2_reg & ~sel_prev_reg;
    // Short code occupies the low eight digits
    assign first_pos = long_reg ? LONG_FIRST : SHORT_FIRST;
    assign cur_digit = code_reg[(4'hF - pos_reg) * 4 +: 4];

    // Hold timer for auto-repeat
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hold_reg <= '0;
            rep_reg <= '0;
        end
        else if (sync2_reg.plus ^ sync2_reg.minus)
        begin
            if (hold_reg < HOLD_COUNT)
            begin
                hold_reg <= hold_reg + 32'h1;
                rep_reg <= '0;
            end
            else if (rep_reg >= REPEAT_COUNT - 1)
                rep_reg <= '0;
            else
                rep_reg <= rep_reg + 32'h1;
        end
        else
        begin
            hold_reg <= '0;
            rep_reg <= '0;
        end
    end

    // One repeat pulse shared by both directions
    assign repeat_tick = hold_reg >= HOLD_COUNT && rep_reg == 0;
    assign step_dn = press.minus | (sync2_reg.minus && !sync2_reg.plus && repeat_tick);
    assign step_up = press.plus | (sync2_reg.plus && !sync2_reg.minus && repeat_tick);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b1;
        end
        else if (state_reg != ST_ENTRY)
        begin
            // Restart so entry opens with the digit lit
            blink_cnt_reg <= '0;
            blink_reg <= 1'b1;
        end
        else if (blink_cnt_reg >= BLINK_COUNT - 1)
        begin
            blink_cnt_reg <= '0;
            blink_reg <= ~blink_reg;
        end
        else
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end

    // Menu state machine
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ST_IO;
            pos_reg <= 4'h0;
            code_reg <= '0;
            long_reg <= 1'b0;
            compare_req <= 1'b0;
            protect_cancel <= 1'b0;
            protect_restore <= 1'b0;
            clear_req <= 1'b0;
        end
        else
        begin
            compare_req <= 1'b0;
            protect_cancel <= 1'b0;
            protect_restore <= 1'b0;
            clear_req <= 1'b0;
            case (state_reg)
                ST_IO:
                    if (press.ok)
                        state_reg <= ST_MENU;
                ST_MENU:
                    if (press.esc)
                        state_reg <= ST_IO;
                    else if (sel_press && menu_item == PPM_ITEM_PASSCODE)
                    begin
                        if (!code_state.registered)
                            state_reg <= ST_NOT_SET;
                        else if (code_state.cancelled)
                            state_reg <= ST_REENABLE;
                        else
                        begin
                            state_reg <= ST_ENTRY;
                            long_reg <= code_state.long_code;
                            pos_reg <= code_state.long_code ? LONG_FIRST : SHORT_FIRST;
                            code_reg <= '0;
                        end
                    end
                    else if (sel_press && menu_item == PPM_ITEM_CLEAR)
                        state_reg <= ST_CLEAR_ASK;
                ST_NOT_SET:
                    if (press.esc || press.ok)
                        state_reg <= ST_MENU;
                ST_ENTRY:
                    if (press.esc)
                    begin
                        if (pos_reg == first_pos)
                        begin
                            code_reg <= '0;
                            state_reg <= ST_MENU;
                        end
                        else
                        begin
                            code_reg[(4'hF - pos_reg) * 4 +: 4] <= DIGIT_MIN;
                            pos_reg <= pos_reg - 4'h1;
                        end
                    end
                    else if (press.ok)
                    begin
                        if (pos_reg == LAST_POS)
                        begin
                            compare_req <= 1'b1;
                            state_reg <= ST_WAIT_CMP;
                        end
                        else
                            pos_reg <= pos_reg + 4'h1;
                    end
                    else if (step_up && cur_digit != DIGIT_MAX)
                        code_reg[(4'hF - pos_reg) * 4 +: 4] <= cur_digit + 4'h1;
                    else if (step_dn && cur_digit != DIGIT_MIN)
                        code_reg[(4'hF - pos_reg) * 4 +: 4] <= cur_digit - 4'h1;
                ST_WAIT_CMP:
                    // Comparison lives in the main unit; code never read back
                    if (compare_done)
                    begin
                        if (compare_match)
                        begin
                            protect_cancel <= 1'b1;
                            state_reg <= ST_ALL_OK;
                        end
                        else
                            state_reg <= ST_BAD;
                        code_reg <= '0;
                    end
                ST_ALL_OK, ST_BAD, ST_RUNNING:
                    if (press.ok || press.esc)
                        state_reg <= ST_MENU;
                ST_REENABLE:
                    if (press.ok)
                    begin
                        protect_restore <= 1'b1;
                        state_reg <= ST_MENU;
                    end
                    else if (press.esc)
                        state_reg <= ST_MENU;
                ST_CLEAR_ASK:
                    if (press.ok)
                    begin
                        if (stop_sync2_reg)
                        begin
                            // device groups chosen by main unit
                            clear_req <= 1'b1;
                            state_reg <= ST_MENU;
                        end
                        else
                            state_reg <= ST_RUNNING;
                    end
                    else if (press.esc)
                        state_reg <= ST_MENU;
                default:
                    state_reg <= ST_IO;
            endcase
        end
    end

    // Drives what the display shows
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            view <= '{PPM_SCR_IO_STATUS, 64'h0, 4'h0, 1'b0};
        else
        begin
            if (state_reg == ST_ENTRY || state_reg == ST_WAIT_CMP)
                view.digits <= code_reg;
            else
                view.digits <= '0;
            view.cursor <= pos_reg;
            view.blink_on <= blink_reg && state_reg == ST_ENTRY;
            case (state_reg)
                ST_IO: view.screen <= PPM_SCR_IO_STATUS;
                ST_MENU: view.screen <= PPM_SCR_MENU;
                ST_NOT_SET: view.screen <= PPM_SCR_NOT_SET;
                ST_ENTRY, ST_WAIT_CMP: view.screen <= long_reg ? PPM_SCR_ENTRY_16 : PPM_SCR_ENTRY_8;
                ST_ALL_OK: view.screen <= PPM_SCR_ALL_OK;
                ST_BAD: view.screen <= PPM_SCR_BAD_CODE;
                ST_REENABLE: view.screen <= PPM_SCR_REENABLE;
                ST_CLEAR_ASK: view.screen <= PPM_SCR_CLEAR_ASK;
                ST_RUNNING: view.screen <= PPM_SCR_RUNNING;
                default: view.screen <= PPM_SCR_IO_STATUS;
            endcase
        end
    end

    assign compare_code = code_reg;
endmodule : ppm_menu

// ---- verification/ppm_menu_checker.sv ----
`timescale 1ns/1ps
module ppm_menu_checker
import ppm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ctrl_stopped,
    input wire ppm_view_t view,
    input wire logic compare_req,
    input wire logic protect_cancel,
    input wire logic protect_restore,
    input wire logic clear_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic in_entry;
    logic [3:0] dig_now;
    logic [3:0] dig_prev;
    assign in_entry = view.screen == PPM_SCR_ENTRY_16 || view.screen == PPM_SCR_ENTRY_8;
    assign dig_now = view.digits[{4'hF - view.cursor, 2'b00} +: 4];
    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst)
            dig_prev <= 4'h0;
        else
            dig_prev <= dig_now;
    AST_ENTRY_START:
        assert property ($rose(in_entry) |-> view.cursor == (view.screen == PPM_SCR_ENTRY_8 ? 4'h8 : 4'h0))
        else $error("entry not at highest digit");
    AST_SHORT_CURSOR:
        assert property (view.screen == PPM_SCR_ENTRY_8 |-> view.cursor >= 4'h8) else $error("short code cursor");
    AST_CURSOR_STEP:
        assert property (in_entry && $past(in_entry) |-> view.cursor == $past(view.cursor)
            || view.cursor == $past(view.cursor) + 4'h1 || view.cursor == $past(view.cursor) - 4'h1)
        else $error("cursor jumped");
    AST_DIGIT_STEP:
        assert property (in_entry && $past(in_entry) && $stable(view.cursor) |-> dig_now == dig_prev
            || (dig_now == dig_prev + 4'h1 && dig_prev != 4'hF) || (dig_now == dig_prev - 4'h1 && dig_prev != 4'h0))
        else $error("digit wrapped or jumped");
    AST_REQ_LAST:
        assert property (compare_req |-> in_entry && view.cursor == LAST_POS ##1 !compare_req)
        else $error("compare not from final digit");
    AST_CANCEL_SHOWS:
        assert property ($rose(protect_cancel) |-> ##[1:2] view.screen == PPM_SCR_ALL_OK) else $error("no success");
    AST_RESTORE_MENU:
        assert property (protect_restore |-> view.screen == PPM_SCR_REENABLE ##[1:2] view.screen == PPM_SCR_MENU)
        else $error("restore path wrong");
    AST_CLEAR_STOPPED:
        assert property (clear_req |-> ctrl_stopped && $past(ctrl_stopped, 3)) else $error("clear while running");
    AST_CLEAR_MENU:
        assert property (clear_req |-> view.screen == PPM_SCR_CLEAR_ASK ##[1:2] view.screen == PPM_SCR_MENU)
        else $error("clear path wrong");
endmodule : ppm_menu_checker

bind ppm_menu ppm_menu_checker i_ppm_menu_checker (.sys_clk(sys_clk), .nrst(nrst), .ctrl_stopped(ctrl_stopped),
    .view(view), .compare_req(compare_req), .protect_cancel(protect_cancel), .protect_restore(protect_restore),
    .clear_req(clear_req));

// ---- verification/ppm_main_unit.sv ----
`timescale 1ns/1ps
module ppm_main_unit
import ppm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic compare_req,
    input wire logic [63:0] compare_code,
    input wire logic [63:0] stored_code,
    input wire logic [7:0] delay,
    output logic compare_done,
    output logic compare_match
);
    logic busy;
    logic hit;
    logic [7:0] wait_cnt;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy <= 1'b0;
            hit <= 1'b0;
            wait_cnt <= 8'h00;
            compare_done <= 1'b0;
            compare_match <= 1'b0;
        end
        else
        begin
            compare_done <= 1'b0;
            // Match toggles outside answers, never a stale level
            compare_match <= ~compare_match;
            if (compare_req)
            begin
                busy <= 1'b1;
                wait_cnt <= delay;
                hit <= compare_code === stored_code;
            end
            else if (busy && wait_cnt == 8'h00)
            begin
                busy <= 1'b0;
                compare_done <= 1'b1;
                compare_match <= hit;
            end
            else if (busy)
                wait_cnt <= wait_cnt - 8'h01;
        end
    end
endmodule : ppm_main_unit

// ---- verification/ppm_menu_test.sv ----
`timescale 1ns/1ps
module ppm_menu_test;
import ppm_pkg::*;
    localparam ppm_buttons_t B_ESC = 4'h8;
    localparam ppm_buttons_t B_MIN = 4'h4;
    localparam ppm_buttons_t B_PLU = 4'h2;
    localparam ppm_buttons_t B_OK = 4'h1;
    logic sys_clk, nrst, menu_select, ctrl_stopped, compare_done, compare_match, compare_req;
    logic protect_cancel, protect_restore, clear_req;
    logic [7:0] delay;
    logic [63:0] compare_code, stored_code;
    ppm_buttons_t buttons;
    ppm_item_t menu_item;
    ppm_code_state_t code_state;
    ppm_view_t view;
    int errors, tests_run, n_cancel, n_restore, n_clear;
    // Short counts keep the hold test fast
    ppm_menu #(.HOLD_COUNT(20), .REPEAT_COUNT(4), .BLINK_COUNT(8)) i_ppm_menu (.sys_clk(sys_clk), .nrst(nrst),
        .buttons(buttons), .menu_item(menu_item), .menu_select(menu_select), .code_state(code_state),
        .ctrl_stopped(ctrl_stopped), .compare_done(compare_done), .compare_match(compare_match), .view(view),
        .compare_req(compare_req), .compare_code(compare_code), .protect_cancel(protect_cancel),
        .protect_restore(protect_restore), .clear_req(clear_req));
    ppm_main_unit i_ppm_main_unit (.sys_clk(sys_clk), .nrst(nrst), .compare_req(compare_req),
        .compare_code(compare_code), .stored_code(stored_code), .delay(delay), .compare_done(compare_done),
        .compare_match(compare_match));
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        n_cancel += int'(protect_cancel === 1'b1);
        n_restore += int'(protect_restore === 1'b1);
        n_clear += int'(clear_req === 1'b1);
    end
    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // Released long enough for sync and view lag
    task press(input ppm_buttons_t b, input int hold);
        buttons = b;
        tick(hold);
        buttons = '0;
        tick(8);
    endtask : press
    task pick(input ppm_item_t it);
        menu_item = it;
        menu_select = 1'b1;
        tick(4);
        menu_select = 1'b0;
        tick(8);
    endtask : pick
    function automatic logic [3:0] dig(input logic [3:0] p);
        return view.digits[{4'hF - p, 2'b00} +: 4];
    endfunction : dig
    task end_of_test;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task t_menu;
        check("screen", view.screen, PPM_SCR_IO_STATUS);
        check("blink", view.blink_on, 1'b0);
        press(B_OK, 4);
        press(B_ESC, 4);
        check("screen", view.screen, PPM_SCR_IO_STATUS);
        press(B_OK, 4);
        check("screen", view.screen, PPM_SCR_MENU);
    endtask : t_menu
    task automatic t_screens;
        ppm_code_state_t cs [4] = '{3'b000, 3'b110, 3'b100, 3'b101};
        ppm_screen_t sc [4] = '{PPM_SCR_NOT_SET, PPM_SCR_ENTRY_16, PPM_SCR_ENTRY_8, PPM_SCR_REENABLE};
        for (int i = 0; i < 4; i++)
        begin
            code_state = cs[i];
            pick(PPM_ITEM_PASSCODE);
            check("screen", view.screen, sc[i]);
            press(B_ESC, 4);
            check("screen", view.screen, PPM_SCR_MENU);
        end
        check("restore", n_restore, 0);
    endtask : t_screens
    task t_entry8;
        logic b0;
        code_state = 3'b100;
        pick(PPM_ITEM_PASSCODE);
        b0 = view.blink_on;
        tick(8);
        check("blink", view.blink_on, !b0);
        press(B_MIN, 4);
        check("digit", dig(4'h8), 4'h0);
        press(B_PLU, 4);
        check("digit", dig(4'h8), 4'h1);
        press(B_MIN, 4);
        check("digit", dig(4'h8), 4'h0);
        press(B_PLU, 200);
        check("digit", dig(4'h8), 4'hF);
        press(B_MIN, 200);
        check("digit", dig(4'h8), 4'h0);
        press(B_OK, 4);
        check("cursor", view.cursor, 4'h9);
        press(B_PLU, 4);
        press(B_ESC, 4);
        check("cursor", view.cursor, 4'h8);
        check("digit", dig(4'h9), 4'h0);
        repeat (6) press(B_OK, 4);
        press(B_PLU, 4);
        press(B_OK, 4);
        repeat (2) press(B_PLU, 4);
        check("code", compare_code, 64'h12);
        press(B_OK, 4);
        check("screen", view.screen, PPM_SCR_ALL_OK);
        check("cancel", n_cancel, 1);
        press(B_OK, 4);
    endtask : t_entry8
    task t_bad16;
        code_state = 3'b110;
        delay = 8'h28;
        pick(PPM_ITEM_PASSCODE);
        repeat (16) press(B_OK, 4);
        tick(50);
        check("screen", view.screen, PPM_SCR_BAD_CODE);
        check("cancel", n_cancel, 1);
        press(B_ESC, 4);
    endtask : t_bad16
    task t_reenable;
        code_state = 3'b101;
        pick(PPM_ITEM_PASSCODE);
        press(B_PLU, 4);
        press(B_MIN, 4);
        check("screen", view.screen, PPM_SCR_REENABLE);
        press(B_OK, 4);
        check("restore", n_restore, 1);
        check("screen", view.screen, PPM_SCR_MENU);
    endtask : t_reenable
    task t_clear;
        ctrl_stopped = 1'b1;
        pick(PPM_ITEM_CLEAR);
        press(B_PLU, 4);
        press(B_MIN, 4);
        check("screen", view.screen, PPM_SCR_CLEAR_ASK);
        press(B_ESC, 4);
        check("screen", view.screen, PPM_SCR_MENU);
        check("clear", n_clear, 0);
        pick(PPM_ITEM_CLEAR);
        press(B_OK, 4);
        check("clear", n_clear, 1);
        check("screen", view.screen, PPM_SCR_MENU);
        ctrl_stopped = 1'b0;
        tick(4);
        pick(PPM_ITEM_CLEAR);
        press(B_OK, 4);
        check("screen", view.screen, PPM_SCR_RUNNING);
        press(B_ESC, 4);
        check("screen", view.screen, PPM_SCR_MENU);
        check("clear", n_clear, 1);
    endtask : t_clear
    initial
    begin
        nrst = 1'b0;
        buttons = '0;
        menu_item = PPM_ITEM_NONE;
        menu_select = 1'b0;
        code_state = '0;
        ctrl_stopped = 1'b0;
        stored_code = 64'h12;
        delay = 8'h00;
        tick(16);
        nrst = 1'b1;
        tick(4);
        t_menu;
        t_screens;
        t_entry8;
        t_bad16;
        t_reenable;
        t_clear;
        end_of_test;
    end
    // Run needs about 1230 cycles
    initial
    begin
        #400000;
        errors++;
        end_of_test;
    end
endmodule : ppm_menu_test
